// ---- eight_bit_port_with_analog_wakeup_test.sv ----
// Testbench: register table rows, wakeup, retention and reset cases
`timescale 1ns/1ps
module eight_bit_port_with_analog_wakeup_test;
  import epawk_pkg::*;
  logic        clk = 0, resetn = 0, wr = 0, rd = 0;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wd = 8'h00, wake = 8'h00, ext_en = 8'hC0, q, pin_in, po, oe, pu, ana, kwi;
  int          error_cnt = 0, checks_done = 0;
  logic [27:0] rows [6] = '{{EPAWK_OFS_LATCH, 8'hA5, 8'hA5}, {EPAWK_OFS_DIR, 8'h3C, 8'h3C},
    {EPAWK_OFS_PU, 8'hFF, 8'hFF}, {EPAWK_OFS_FUNC, 8'h0F, 8'h0F},
    {EPAWK_OFS_PRD, 8'h55, 8'h40}, {12'h123, 8'h77, 8'h00}};
  epawk_port DUT (.clk(clk), .resetn(resetn), .reg_addr(addr), .reg_wdata(wd), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(q), .pin_in(pin_in), .pin_out(po), .pin_oe(oe), .pullup_en(pu),
    .key_wakeup_enable_bit(wake), .analog_input_channel(ana), .key_wakeup_input(kwi));
  epawk_board u_brd (.pin_out(po), .pin_oe(oe), .pullup_en(pu), .ext_val(8'h5A),
    .ext_en(ext_en), .pin_in(pin_in));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task chk(input logic [7:0] s, input logic [7:0] e, input string n);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wrt(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wd, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  endtask : wrt
  task rdc(input logic [11:0] a, input logic [7:0] e, input string n);
    @(posedge clk) {addr, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 chk(q, e, n);
  endtask : rdc
  task test_done;
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  initial begin
    #5000 error_cnt++;
    test_done;
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      wrt(rows[i][27:16], rows[i][15:8]);
      rdc(rows[i][27:16], rows[i][7:0], "register");
    end
    chk(oe, 8'h30, "oe");
    chk(po & oe, 8'h20, "drive");
    chk(pu, 8'hC0, "pullup");
    chk(ana, 8'h0F, "analog");
    @(posedge clk) {wake, ext_en} <= {8'h30, 8'hF0};
    repeat (8) @(posedge clk);
    #1 chk(oe, 8'h00, "oe_wake");
    chk(pu, 8'hF0, "pu_wake");
    chk(kwi, 8'h10, "wake_in");
    @(posedge clk) {wake, ext_en} <= 16'h0000;
    wrt(EPAWK_OFS_FUNC, 8'h00);
    wrt(EPAWK_OFS_DIR, 8'hFF);
    rdc(EPAWK_OFS_PRD, 8'h00, "readback_out");
    chk(oe, 8'hFF, "oe_all");
    chk(po, 8'hA5, "latch_kept");
    chk(pu, 8'h00, "pu_out");
    @(posedge clk) resetn <= 1'b0;
    @(posedge clk) resetn <= 1'b1;
    #1 chk(oe | po, 8'h00, "reset_pins");
    repeat (3) @(posedge clk);
    foreach (rows[i]) if (i < 4) rdc(rows[i][27:16], 8'h00, "reset_value");
    test_done;
  end
endmodule : eight_bit_port_with_analog_wakeup_test

// ---- epawk_board.sv ----
// Board model: resolves each pin from port drive, board drive and pull-up
`timescale 1ns/1ps
module epawk_board (
  // Port side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_en,
  // Board side
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_in
);
  // Floating pins toggle so a stale level never reads as valid
  logic [7:0] flt = 8'h00;
  always #7 flt = ~flt;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else pin_in[i] = pullup_en[i] | flt[i];
    end
  end
endmodule : epawk_board

// ---- epawk_pkg.sv ----
// Package: register map and reset values for the eight-bit port
package epawk_pkg;
  localparam int          EPAWK_WIDTH     = 8;
  localparam int          EPAWK_ADDR_W    = 12;
  localparam logic [11:0] EPAWK_OFS_LATCH = 12'h004;
  localparam logic [11:0] EPAWK_OFS_PRD   = 12'h011;
  localparam logic [11:0] EPAWK_OFS_DIR   = 12'hF1E;
  localparam logic [11:0] EPAWK_OFS_PU    = 12'hF2B;
  localparam logic [11:0] EPAWK_OFS_FUNC  = 12'hF38;
  localparam logic [7:0]  EPAWK_RST_LATCH = 8'h00;
  localparam logic [7:0]  EPAWK_RST_DIR   = 8'h00;
  localparam logic [7:0]  EPAWK_RST_PU    = 8'h00;
  localparam logic [7:0]  EPAWK_RST_FUNC  = 8'h00;
  localparam logic [7:0]  EPAWK_RST_ZERO  = 8'h00;
endpackage : epawk_pkg

// ---- epawk_port.sv ----
// Eight-bit GPIO port with analog and key wakeup routing
// Contract
// - Eight pins, direction bit each, reset input
// - Output latch drives pin level in output
// - Function bit routes pin to analog channel
// - Pull-up only when wakeup or plain input
// - Readback gives pin level, else zero
// - Wakeup works without setting direction bit
// - Wakeup works without setting function bit
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module epawk_port
  import epawk_pkg::*;
#(
  parameter int W = EPAWK_WIDTH
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    resetn,
  // Register port
  input  wire logic [EPAWK_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  // Pins
  input  wire logic [W-1:0]            pin_in,
  output logic      [W-1:0]            pin_out,
  output logic      [W-1:0]            pin_oe,
  output logic      [W-1:0]            pullup_en,
  // Wakeup enables from the wakeup controller, per pin
  input  wire logic [W-1:0]            key_wakeup_enable_bit,
  // Toward converter and wakeup controller
  output logic      [W-1:0]            analog_input_channel,
  output logic      [W-1:0]            key_wakeup_input
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1_r;
  logic rst_n_r;

  // Assert at once, release on the clock so no flop sees a runt edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [W-1:0] port_output_latch_r;
  logic [W-1:0] port_direction_control_r;
  logic [W-1:0] port_pullup_control_r;
  logic [W-1:0] port_function_select_r;
  logic [W-1:0] pin_level;
  logic [W-1:0] port_pin_readback;
  logic         wr_latch;
  logic         wr_dir;
  logic         wr_pu;
  logic         wr_func;

  // Readback and unmapped offsets decode to no write at all
  assign wr_latch = reg_wr && (reg_addr == EPAWK_OFS_LATCH);
  assign wr_dir   = reg_wr && (reg_addr == EPAWK_OFS_DIR);
  assign wr_pu    = reg_wr && (reg_addr == EPAWK_OFS_PU);
  assign wr_func  = reg_wr && (reg_addr == EPAWK_OFS_FUNC);

  // Latch is written regardless of mode, so it is never lost
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      port_output_latch_r <= EPAWK_RST_LATCH;
    end else if (wr_latch) begin
      port_output_latch_r <= reg_wdata[W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      port_direction_control_r <= EPAWK_RST_DIR;
    end else if (wr_dir) begin
      port_direction_control_r <= reg_wdata[W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      port_pullup_control_r <= EPAWK_RST_PU;
    end else if (wr_pu) begin
      port_pullup_control_r <= reg_wdata[W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      port_function_select_r <= EPAWK_RST_FUNC;
    end else if (wr_func) begin
      port_function_select_r <= reg_wdata[W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin input path
  // ----------------------------------------------------------------
  epawk_sync #(
    .W (W)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n_r),
    .d     (pin_in),
    .q     (pin_level)
  );

  // ----------------------------------------------------------------
  // Pin mode decode
  // ----------------------------------------------------------------
  logic [W-1:0] plain_input;
  logic [W-1:0] pin_oe_nxt;
  logic [W-1:0] pullup_en_nxt;
  logic [W-1:0] key_wakeup_input_nxt;

  // Plain input: neither output mode nor analog route selected
  assign plain_input       = ~port_direction_control_r & ~port_function_select_r;
  assign port_pin_readback = pin_level & plain_input;

  // Wakeup overrides the direction bit, so a key is never fought
  always_comb begin
    pin_oe_nxt = port_direction_control_r & ~port_function_select_r
                 & ~key_wakeup_enable_bit;
  end

  // Stored pull-up bits only reach the pad in the allowed modes
  always_comb begin
    pullup_en_nxt = port_pullup_control_r
                    & (key_wakeup_enable_bit | plain_input);
  end

  // Wakeup sees the filtered pin regardless of direction or function
  always_comb begin
    key_wakeup_input_nxt = pin_level & key_wakeup_enable_bit;
  end

  // ----------------------------------------------------------------
  // Read data select
  // ----------------------------------------------------------------
  logic [7:0] reg_rdata_nxt;

  // Zero outside the answer cycle keeps a shared read mux simple
  always_comb begin
    reg_rdata_nxt = EPAWK_RST_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        EPAWK_OFS_LATCH: reg_rdata_nxt = port_output_latch_r;
        EPAWK_OFS_PRD:   reg_rdata_nxt = port_pin_readback;
        EPAWK_OFS_DIR:   reg_rdata_nxt = port_direction_control_r;
        EPAWK_OFS_PU:    reg_rdata_nxt = port_pullup_control_r;
        EPAWK_OFS_FUNC:  reg_rdata_nxt = port_function_select_r;
        default:         reg_rdata_nxt = EPAWK_RST_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata <= EPAWK_RST_ZERO;
    end else begin
      reg_rdata <= reg_rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive and routing
  // ----------------------------------------------------------------
  // Analog select or wakeup overrides output drive so the pin floats
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_oe <= '0;
    end else begin
      pin_oe <= pin_oe_nxt;
    end
  end

  // Latch shows even while undriven; the pad ignores it until enabled
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_out <= '0;
    end else begin
      pin_out <= port_output_latch_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pullup_en <= '0;
    end else begin
      pullup_en <= pullup_en_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      analog_input_channel <= '0;
    end else begin
      analog_input_channel <= port_function_select_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      key_wakeup_input <= '0;
    end else begin
      key_wakeup_input <= key_wakeup_input_nxt;
    end
  end
endmodule : epawk_port

// ---- epawk_port_checker.sv ----
// Checker: pin and read-data relations of the port
`timescale 1ns/1ps
module epawk_port_checker
  import epawk_pkg::*;
(
  // Clock, reset and register port
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Pins and routing
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe,
  input wire logic [7:0]  pullup_en,
  input wire logic [7:0]  key_wakeup_enable_bit,
  input wire logic [7:0]  analog_input_channel,
  input wire logic [7:0]  key_wakeup_input
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_WAKE_OE: assert property ((pin_oe & $past(key_wakeup_enable_bit)) == 8'h00)
    else $error("pin driven while wakeup enabled");
  AST_ANA_OE: assert property ((pin_oe & analog_input_channel) == 8'h00)
    else $error("pin driven while routed to analog");
  AST_PU_ANA: assert property (
    (pullup_en & analog_input_channel & ~$past(key_wakeup_enable_bit)) == 8'h00)
    else $error("pull-up on analog pin");
  AST_PU_OE: assert property ((pullup_en & pin_oe) == 8'h00)
    else $error("pull-up on output pin");
  AST_KWI: assert property ((key_wakeup_input & ~$past(key_wakeup_enable_bit)) == 8'h00)
    else $error("wakeup input without enable");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read answer");
  AST_PRD_MASK: assert property (
    $past(reg_rd && reg_addr == EPAWK_OFS_PRD)
    |-> (reg_rdata & (analog_input_channel | pin_oe)) == 8'h00)
    else $error("readback not zero on output or analog pin");
  AST_LATCH_HOLD: assert property (
    !$past(reg_wr && reg_addr == EPAWK_OFS_LATCH, 2) |-> $stable(pin_out))
    else $error("pin level changed without latch write");
endmodule : epawk_port_checker
bind epawk_port epawk_port_checker u_chk (
  .clk                   (clk),
  .resetn                (resetn),
  .reg_addr              (reg_addr),
  .reg_wr                (reg_wr),
  .reg_rd                (reg_rd),
  .reg_rdata             (reg_rdata),
  .pin_out               (pin_out),
  .pin_oe                (pin_oe),
  .pullup_en             (pullup_en),
  .key_wakeup_enable_bit (key_wakeup_enable_bit),
  .analog_input_channel  (analog_input_channel),
  .key_wakeup_input      (key_wakeup_input)
);

// ---- epawk_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module epawk_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a new level only once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  end
endmodule : epawk_sync
